// ### logic/tpw_consts.svh
/*
  Offsets, field positions, reset values and counts of the PWM timer channel.
  Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
*/
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH

// Register byte offsets
`define TPW_ADDR_W          5
`define TPW_OFS_MODE        5'h00
`define TPW_OFS_COUNT       5'h04
`define TPW_OFS_CTRL        5'h08
`define TPW_OFS_STATUS      5'h0C
`define TPW_OFS_MASK        5'h10

// Mode register fields
`define TPW_MODE_OP_LO      0
`define TPW_MODE_OP_HI      1
`define TPW_MODE_OUT_EN     2
`define TPW_MODE_EDGE       3
`define TPW_MODE_TRIG_KIND  4
`define TPW_MODE_WIDTH      5
`define TPW_MODE_CKS_LO     6
`define TPW_MODE_CKS_HI     7
`define TPW_MODE_PWM        2'h3
`define TPW_MODE_RST        8'h00

// Control register fields
`define TPW_CTRL_START      0
`define TPW_CTRL_ONESHOT    1
`define TPW_CTRL_TSRC_LO    2
`define TPW_CTRL_TSRC_HI    3

// Trigger source codes
`define TPW_TSRC_PIN        2'h0
`define TPW_TSRC_PREV       2'h1
`define TPW_TSRC_NEXT       2'h2

// Count source codes
`define TPW_CKS_BASE        2'h0
`define TPW_CKS_DIV8        2'h1
`define TPW_CKS_DIV32       2'h2

// Status and mask fields
`define TPW_ST_FALL         0
`define TPW_ST_RUN          1
`define TPW_ST_LEVEL        2

// Modulator periods in modulator ticks, prescaled in 8-bit mode
`define TPW_PERIOD16        16'hFFFF
`define TPW_PERIOD8         16'h00FF
`define TPW_DIV8_LAST       5'h07
`define TPW_DIV32_LAST      5'h1F

`endif

// ### logic/tpw_pkg.sv
/*
  Types of the PWM timer channel.
  Assumes the constants header is included by every user of the package.
*/
package tpw_pkg;

  typedef struct packed {
    logic [1:0] cks;
    logic       width8;
    logic       trig_kind;
    logic       edge_rise;
    logic       out_en;
    logic [1:0] op;
  } tpw_mode_t;

  typedef struct packed {
    logic prev_evt;
    logic next_evt;
    logic pin;
  } tpw_trig_t;

  typedef enum logic [1:0] {
    TPW_IDLE,
    TPW_ARMED,
    TPW_RUN
  } tpw_state_t;

endpackage

// ### logic/tpw_tick_gen.sv
/*
  Count-source tick generator: base, half, divide-by-8 and divide-by-32 ticks.
  Assumes a single clock; the tick is a one-cycle pulse.
*/
`timescale 1ns/1ps
`include "tpw_consts.svh"

module tpw_tick_gen
  import tpw_pkg::*;
#(
  parameter bit BASE_HALF = 1'b0
)(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] cks,
  output logic            tick
);

  logic [4:0] div_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running divider
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_ff <= 5'h0_0;
    else if (clk_en)
      div_ff <= div_ff + 5'h0_1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source select
  always_comb
  begin
    case (cks)
      `TPW_CKS_BASE:  tick = clk_en & (BASE_HALF ? div_ff[0] : 1'b1);
      `TPW_CKS_DIV8:  tick = clk_en & ({2'h0, div_ff[2:0]} == `TPW_DIV8_LAST);
      `TPW_CKS_DIV32: tick = clk_en & (div_ff == `TPW_DIV32_LAST);
      default:        tick = 1'b0;
    endcase
  end

endmodule // tpw_tick_gen

// ### logic/tpw_channel.sv
/*
  PWM mode of one down-counting timer channel with Avalon-MM registers.
  Assumes neighbour overflow events arrive as one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
`include "tpw_consts.svh"

module tpw_channel
  import tpw_pkg::*;
#(
  parameter bit BASE_HALF = 1'b0
)(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire tpw_trig_t   trig_in,
  output logic             pulse_output_pin,
  output logic             reload_evt,
  output logic             irq
);

  tpw_mode_t   mode_ff;
  logic [15:0] reload_ff;
  logic [15:0] cnt_ff;
  logic [15:0] per_ff;
  logic [7:0]  pre_ff;
  logic        start_ff;
  logic [1:0]  tsrc_ff;
  logic        oneshot_ff;
  logic        pin_ff;
  logic        out_ff;
  logic        first_ff;
  logic        fall_ff;
  logic        mask_ff;
  logic        rd_ack_ff;
  logic [31:0] rdata_ff;
  logic        reload_ff_evt;
  tpw_state_t  state_ff;
  tpw_state_t  nxt_state;

  logic        tick;
  logic        eff_tick;
  logic        pwm_sel;
  logic        trig_evt;
  logic        pin_edge;
  logic        wr_ok;
  logic        fall_set;
  logic [15:0] nxt_n;
  logic [15:0] nxt_per;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_ok = avs_write & clk_en;
  assign avs_waitrequest = (avs_write & ~clk_en) | (avs_read & ~(clk_en & rd_ack_ff));
  assign avs_readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Count source
  tpw_tick_gen #(
    .BASE_HALF (BASE_HALF)
  ) u_tick (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .cks     (mode_ff.cks),
    .tick    (tick)
  );

  assign pwm_sel = (mode_ff.op == `TPW_MODE_PWM);

  // 8-bit modulator ticks only when the prescaler wraps
  assign eff_tick = tick & (~mode_ff.width8 | (pre_ff == 8'h00));

  ////////////////////////////////////////////////////////////////////////////
  // Trigger detection
  always_comb
  begin
    pin_edge = mode_ff.edge_rise ? (trig_in.pin & ~pin_ff)
                                 : (~trig_in.pin & pin_ff);
    case (tsrc_ff)
      `TPW_TSRC_PIN:  trig_evt = pin_edge;
      `TPW_TSRC_PREV: trig_evt = trig_in.prev_evt;
      `TPW_TSRC_NEXT: trig_evt = trig_in.next_evt;
      default:        trig_evt = trig_in.prev_evt | trig_in.next_evt;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      pin_ff <= 1'b0;
    else if (clk_en)
      pin_ff <= trig_in.pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      TPW_IDLE:
      begin
        if (start_ff && pwm_sel)
          nxt_state = TPW_ARMED;
      end
      TPW_ARMED:
      begin
        if (!start_ff || !pwm_sel)
          nxt_state = TPW_IDLE;
        else if (!mode_ff.trig_kind || trig_evt || oneshot_ff)
          nxt_state = TPW_RUN;
      end
      TPW_RUN:
      begin
        if (!start_ff || !pwm_sel)
          nxt_state = TPW_IDLE;
        else
          nxt_state = TPW_RUN;
      end
      default: nxt_state = TPW_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= TPW_IDLE;
    else if (clk_en)
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modulator
  always_comb
  begin
    nxt_n   = mode_ff.width8 ? {8'h00, reload_ff[15:8]} : reload_ff;
    nxt_per = mode_ff.width8 ? `TPW_PERIOD8 : `TPW_PERIOD16;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_ff        <= 16'h0000;
      per_ff        <= 16'h0000;
      pre_ff        <= 8'h00;
      out_ff        <= 1'b0;
      first_ff      <= 1'b0;
      reload_ff_evt <= 1'b0;
    end
    else if (clk_en)
    begin
      reload_ff_evt <= 1'b0;
      if (state_ff != TPW_RUN || nxt_state != TPW_RUN)
      begin
        per_ff   <= 16'h0000;
        pre_ff   <= 8'h00;
        out_ff   <= 1'b0;
        first_ff <= 1'b0;
        if (wr_ok && hit(avs_address, `TPW_OFS_COUNT))
          cnt_ff <= avs_writedata[15:0];
      end
      else
      begin
        if (tick)
        begin
          first_ff <= 1'b1;
          pre_ff   <= (pre_ff == 8'h00) ? reload_ff[7:0] : pre_ff - 8'h01;
        end
        if (eff_tick)
        begin
          if (per_ff == 16'h0000)
          begin
            cnt_ff        <= nxt_n;
            per_ff        <= nxt_per - 16'h0001;
            out_ff        <= (nxt_n != 16'h0000);
            reload_ff_evt <= 1'b1;
          end
          else
          begin
            per_ff <= per_ff - 16'h0001;
            if (cnt_ff != 16'h0000)
              cnt_ff <= cnt_ff - 16'h0001;
            out_ff <= (cnt_ff > 16'h0001);
          end
        end
        else if (wr_ok && hit(avs_address, `TPW_OFS_COUNT) && !first_ff)
          cnt_ff <= avs_writedata[15:0];
      end
    end
  end

  assign pulse_output_pin = out_ff & mode_ff.out_en;
  assign reload_evt       = reload_ff_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Falling-edge interrupt
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fall_set <= 1'b0;
    else if (clk_en)
      fall_set <= out_ff & (state_ff == TPW_RUN) & (cnt_ff == 16'h0001) & eff_tick
                  & (per_ff != 16'h0000);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fall_ff <= 1'b0;
    else if (clk_en)
    begin
      if (fall_set)
        fall_ff <= 1'b1;
      else if (wr_ok && hit(avs_address, `TPW_OFS_STATUS) && avs_byteenable[0]
               && avs_writedata[`TPW_ST_FALL])
        fall_ff <= 1'b0;
    end
  end

  assign irq = fall_ff & mask_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_ff    <= tpw_mode_t'(`TPW_MODE_RST);
      reload_ff  <= 16'h0000;
      start_ff   <= 1'b0;
      tsrc_ff    <= 2'h0;
      oneshot_ff <= 1'b0;
      mask_ff    <= 1'b0;
    end
    else if (clk_en)
    begin
      oneshot_ff <= 1'b0;
      if (wr_ok)
      begin
        if (hit(avs_address, `TPW_OFS_MODE) && avs_byteenable[0])
          mode_ff <= tpw_mode_t'(avs_writedata[7:0]);
        if (hit(avs_address, `TPW_OFS_COUNT))
        begin
          if (avs_byteenable[0])
            reload_ff[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1])
            reload_ff[15:8] <= avs_writedata[15:8];
        end
        if (hit(avs_address, `TPW_OFS_CTRL) && avs_byteenable[0])
        begin
          start_ff   <= avs_writedata[`TPW_CTRL_START];
          oneshot_ff <= avs_writedata[`TPW_CTRL_ONESHOT] & ~mode_ff.trig_kind;
          tsrc_ff    <= avs_writedata[`TPW_CTRL_TSRC_HI:`TPW_CTRL_TSRC_LO];
        end
        if (hit(avs_address, `TPW_OFS_MASK) && avs_byteenable[0])
          mask_ff <= avs_writedata[`TPW_ST_FALL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, one wait cycle
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_ack_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      rd_ack_ff <= avs_read & ~rd_ack_ff;
      if (avs_read && !rd_ack_ff)
      begin
        rdata_ff <= 32'h0000_0000;
        if (hit(avs_address, `TPW_OFS_MODE))
          rdata_ff[7:0] <= mode_ff;
        if (hit(avs_address, `TPW_OFS_CTRL))
          rdata_ff[3:0] <= {tsrc_ff, 1'b0, start_ff};
        if (hit(avs_address, `TPW_OFS_STATUS))
          rdata_ff[2:0] <= {out_ff, state_ff == TPW_RUN, fall_ff};
        if (hit(avs_address, `TPW_OFS_MASK))
          rdata_ff[0] <= mask_ff;
        // Counter reads return zero, no live count
      end
    end
  end

endmodule // tpw_channel

// ### tb/tpw_channel_props.sv
/*
  Port checker of the PWM timer channel.
  Assumes one clock, sys_rst async active high, bound to tpw_channel.
*/
`timescale 1ns/1ps
`include "tpw_consts.svh"

module tpw_channel_props (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pulse_output_pin,
  input wire logic        reload_evt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic rd_ok;
  assign rd_ok = avs_read && !avs_waitrequest;

  sequence s_rd_answer;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  sequence s_reload_near;
    reload_evt || $past(reload_evt);
  endsequence

  ////////////////////////////////////////
  AST_WR_NOWAIT: assert property (avs_write && clk_en |-> !avs_waitrequest)
    else $error("write stalled");
  AST_RD_WAIT: assert property ($rose(avs_read) && clk_en |-> s_rd_answer)
    else $error("read answer timing wrong");
  AST_RD_ONE: assert property (rd_ok |-> $past(avs_waitrequest))
    else $error("read answered without wait cycle");
  AST_CNT_RD: assert property (rd_ok && avs_address == `TPW_OFS_COUNT |-> avs_readdata == 0)
    else $error("counter read not zero");
  AST_UNMAP_RD: assert property (rd_ok && avs_address > `TPW_OFS_MASK |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  AST_RELOAD_RISE: assert property ($rose(pulse_output_pin) |-> s_reload_near or ##1 reload_evt)
    else $error("rise without reload");
  AST_RELOAD_GAP: assert property (reload_evt |=> !reload_evt [*8])
    else $error("reloads too close");
  AST_FALL_NO_RELOAD: assert property ($fell(pulse_output_pin) |-> !reload_evt)
    else $error("fall at reload");
endmodule // tpw_channel_props

bind tpw_channel tpw_channel_props tpw_channel_props_inst (.ref_clk, .sys_rst, .clk_en,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .pulse_output_pin,
  .reload_evt);

// ### tb/tb.sv
/*
  Self-checking bench of the PWM timer channel.
  Assumes the base count source ticks every clock cycle.
*/
`timescale 1ns/1ps
`include "tpw_consts.svh"

module tb
  import tpw_pkg::*;
;
  logic        ref_clk;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [4:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  tpw_trig_t   trig_in = '0;
  logic        pulse_output_pin;
  logic        reload_evt;
  logic        irq;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          t0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];

  tpw_channel tpw_channel_inst (.ref_clk, .sys_rst, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
    .trig_in, .pulse_output_pin, .reload_evt, .irq);

  ////////////////////////////////////////
  task automatic results();
    $display("err_total=%0d checked=%0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    checked++;
    if ((got & m) !== (e & m))
    begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("Error %0t: wait ran out", $time);
    results();
  endtask

  task automatic bus(input logic r, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_read <= r;
    avs_write <= !r;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      hang();
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b1, a, 32'h0000_0000);
  endtask

  task automatic lvl(input logic v);
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (pulse_output_pin !== v && n < 70000);
    if (n >= 70000)
      hang();
  endtask

  ////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (!sys_rst && avs_read && avs_waitrequest === 1'b0)
      chk(avs_readdata, exp_q.pop_front(), msk_q.pop_front());
  end

  initial
  begin
    int m;
    int n;
    int dv;
    void'($urandom(49));
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`TPW_OFS_MODE, `TPW_MODE_RST, 32'h0000_00FF);
    rd(5'(20 + 4 * ($urandom % 3)), 0, '1);
    wr(`TPW_OFS_MODE, 32'h0000_0007);
    rd(`TPW_OFS_MODE, 32'h0000_0007, 32'h0000_00FF);
    wr(`TPW_OFS_MASK, 1);
    wr(`TPW_OFS_COUNT, 32'h0000_0014);
    rd(`TPW_OFS_COUNT, 0, '1);
    wr(`TPW_OFS_CTRL, 1);
    lvl(1'b1);
    t0 = cyc;
    lvl(1'b0);
    chk(cyc - t0, 20, '1);
    repeat (3) @(negedge ref_clk);
    chk(irq, 1, 1);
    rd(`TPW_OFS_STATUS, 1, 1);
    wr(`TPW_OFS_MASK, 0);
    @(negedge ref_clk);
    chk(irq, 0, 1);
    wr(`TPW_OFS_MASK, 1);
    wr(`TPW_OFS_STATUS, 1);
    @(negedge ref_clk);
    chk(irq, 0, 1);
    wr(`TPW_OFS_COUNT, 32'h0000_001E);
    lvl(1'b1);
    chk(cyc - t0, 65535, '1);
    t0 = cyc;
    lvl(1'b0);
    chk(cyc - t0, 30, '1);
    for (int k = 0; k < 3; k++)
    begin
      m = $urandom % 2;
      n = 1 + $urandom % 200;
      dv = (k == 0) ? 1 : (k == 1) ? 8 : 32;
      wr(`TPW_OFS_CTRL, 0);
      wr(`TPW_OFS_MODE, 32'(k * 64 + 39));
      wr(`TPW_OFS_COUNT, 32'(n * 256 + m));
      wr(`TPW_OFS_CTRL, 1);
      lvl(1'b1);
      t0 = cyc;
      lvl(1'b0);
      chk(cyc - t0, n * (m + 1) * dv, '1);
      lvl(1'b1);
      chk(cyc - t0, 255 * (m + 1) * dv, '1);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(`TPW_OFS_CTRL, 0);
      rd(`TPW_OFS_STATUS, 0, 2);
      trig_in.pin <= (k == 0);
      wr(`TPW_OFS_MODE, (k == 1) ? 32'h0000_001F : 32'h0000_0017);
      wr(`TPW_OFS_CTRL, 32'((k < 2 ? 0 : k - 1) * 4 + 3));
      rd(`TPW_OFS_STATUS, 0, 2);
      trig_in <= tpw_trig_t'((k < 2) ? 3'(k) : (k == 2) ? 3'b100 : 3'b010);
      @(posedge ref_clk);
      trig_in.prev_evt <= 1'b0;
      trig_in.next_evt <= 1'b0;
      rd(`TPW_OFS_STATUS, 2, 2);
    end
    wr(`TPW_OFS_CTRL, 0);
    results();
  end
endmodule // tb
